// ==== shared/ssla_defines.vh ====
// Constants for the system status indicator arbiter: register map, fields, severities, timing
`ifndef SSLA_DEFINES_VH
`define SSLA_DEFINES_VH

// Register byte offsets
`define SSLA_OFF_CTRL 8'h00
`define SSLA_OFF_BMC_SRC 8'h04
`define SSLA_OFF_FW_SET 8'h08
`define SSLA_OFF_FW_CLR 8'h0c
`define SSLA_OFF_FW_SRC 8'h10
`define SSLA_OFF_STATUS 8'h14
`define SSLA_OFF_CFG 8'h18

// Control fields
`define SSLA_CTRL_UNC_EN 0
`define SSLA_CTRL_DUAL_CPU 1
`define SSLA_CTRL_MIRROR 2
`define SSLA_CTRL_REDUND_PSU 3
`define SSLA_CTRL_RESET 4'h0

// Firmware fault-report bits
`define SSLA_FW_MEM_UNUSABLE 0
`define SSLA_FW_MEM_REDUND_LOST 1
`define SSLA_FW_PCIE_CORR 2
`define SSLA_FW_MEM_CE_LIMIT 3
`define SSLA_FW_PCIE_UNCORR 4
`define SSLA_FW_NO_GOOD_DIMM 5
`define SSLA_FW_MEM_UE 6
`define SSLA_FW_CPU_CONFIG 7
`define SSLA_FW_WIDTH 8

// Severity codes (higher wins)
`define SSLA_SEV_OK 2'h0
`define SSLA_SEV_DEGRADED 2'h1
`define SSLA_SEV_NONFATAL 2'h2
`define SSLA_SEV_FATAL 2'h3

// Blink timing: about 1 Hz, half period 500 ms at 125 MHz
`define SSLA_BLINK_HALF_MS 500
`define SSLA_CLK_KHZ 125000
`define SSLA_BLINK_HALF_CYC (`SSLA_BLINK_HALF_MS * `SSLA_CLK_KHZ)

`endif

// ==== rtl/ssla_sync.v ====
// Three-stage input synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module ssla_sync #(
  parameter WIDTH = 1
) (
  input wire mclk,
  input wire sys_rst,
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] level_out
);
  reg [WIDTH-1:0] s1_reg;
  reg [WIDTH-1:0] s2_reg;
  reg [WIDTH-1:0] s3_reg;
  genvar i;

  // First stage feeds only the second; a change counts once stages two and three agree
  always @(posedge mclk) begin
    if (sys_rst) begin
      s1_reg <= {WIDTH{1'b0}};
      s2_reg <= {WIDTH{1'b0}};
      s3_reg <= {WIDTH{1'b0}};
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_agree
      // Hold last agreed value while stages disagree
      always @(posedge mclk) begin
        if (sys_rst) begin
          level_out[i] <= 1'b0;
        end else if (s2_reg[i] == s3_reg[i]) begin
          level_out[i] <= s3_reg[i];
        end
      end
    end
  endgenerate
endmodule // ssla_sync

// ==== rtl/ssla_blink.v ====
// Free-running blink divider shared by the green and amber blink states
`timescale 1ns/1ps
`include "ssla_defines.vh"
module ssla_blink #(
  parameter HALF_CYC = `SSLA_BLINK_HALF_CYC
) (
  input wire mclk,
  input wire sys_rst,
  output reg blink_phase
);
  reg [31:0] cnt_reg;

  // Divider never stops, so both blink colours share one phase
  always @(posedge mclk) begin
    if (sys_rst) begin
      cnt_reg <= 32'h0000_0000;
      blink_phase <= 1'b0;
    end else if (cnt_reg >= HALF_CYC - 1) begin
      cnt_reg <= 32'h0000_0000;
      blink_phase <= ~blink_phase;
    end else begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
    end
  end
endmodule // ssla_blink

// ==== rtl/ssla_arbiter.v ====
// System status indicator arbiter with AXI4-Lite register slave
// Operation
// - Indicator shows the single most severe fault currently present.
// - Any amber condition overrides every green indication.
// - Combine own sensor conditions with other controllers' reports.
// - Sensor contributions follow current sensor state; most critical wins.
// - State is kept on standby power through DC-off or S5.
// - No fault gives steady green; degraded gives green blink near 1 Hz.
// - Non-fatal alarm gives amber blink near 1 Hz.
// - Fatal alarm gives steady amber, outranking everything.
// - Redundancy loss in redundant subsystem gives degraded.
// - One of two fitted processors disabled gives degraded.
// - Non-critical threshold gives degraded; critical threshold gives non-fatal.
// - Too few working fans for cooling gives non-fatal.
// - PCI Express correctable link errors give degraded.
// - PCI Express uncorrectable link errors give non-fatal.
// - Over ten correctable memory errors without mirroring gives non-fatal.
// - Lost memory redundancy when mirrored gives degraded.
// - Runtime uncorrectable memory error without redundancy gives fatal.
// - Processor configuration error gives fatal.
// - Power-good loss, internal error, thermal trip, missing first processor give fatal.
// - Predictive failure with redundant supplies gives degraded.
// - Upper non-critical tracking off by default; when enabled gives degraded.
`timescale 1ns/1ps
`include "ssla_defines.vh"
module ssla_arbiter #(
  parameter BLINK_HALF_CYC = `SSLA_BLINK_HALF_CYC
) (
  input wire mclk,
  input wire sys_rst,
  // Sensor and other-controller pins
  input wire psu_redund_lost,
  input wire fan_redund_lost,
  input wire cpu_disabled,
  input wire fan_fail,
  input wire thresh_noncrit,
  input wire thresh_upper_noncrit,
  input wire battery_fail,
  input wire psu_predictive_fail,
  input wire thresh_crit,
  input wire regulator_overheat,
  input wire fans_below_min,
  input wire cpu_internal_error,
  input wire cpu1_missing,
  input wire cpu_thermal_trip,
  input wire power_good_lost,
  input wire psu_insufficient,
  input wire hsc_degraded,
  input wire hsc_nonfatal,
  input wire hsc_fatal,
  // AXI4-Lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Indicator drive, active low to the panel, and the severity code
  output reg status_green_n,
  output reg status_amber_n,
  output reg [1:0] severity
);
  localparam NPIN = 19;
  // Configuration word is cut to the bus width on purpose
  localparam [31:0] CFG_WORD = BLINK_HALF_CYC;
  // Bit positions of the pins in the synchronised vector and in the source register
  // Degraded-class sources
  localparam PIN_PSU_REDUND = 0;
  localparam PIN_FAN_REDUND = 1;
  localparam PIN_CPU_OFF = 2;
  localparam PIN_FAN_FAIL = 3;
  localparam PIN_NONCRIT = 4;
  localparam PIN_UPPER_NC = 5;
  localparam PIN_BATTERY = 6;
  localparam PIN_PSU_PRED = 7;
  // Alarm-class sources, except PIN_HSC_DEG, which is a degraded-class source
  localparam PIN_CRIT = 8;
  localparam PIN_REG_HOT = 9;
  localparam PIN_FANS_LOW = 10;
  localparam PIN_CPU_INTERNAL = 11;
  localparam PIN_CPU1_ABSENT = 12;
  localparam PIN_CPU_TRIP = 13;
  localparam PIN_PGOOD_LOST = 14;
  localparam PIN_PSU_SHORT = 15;
  localparam PIN_HSC_DEG = 16;
  localparam PIN_HSC_NF = 17;
  localparam PIN_HSC_FATAL = 18;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  wire [NPIN-1:0] pin_raw;
  wire [NPIN-1:0] pin_s;
  // Each pin lands at its named position, so the source register layout follows the index table
  assign pin_raw[PIN_PSU_REDUND] = psu_redund_lost;
  assign pin_raw[PIN_FAN_REDUND] = fan_redund_lost;
  assign pin_raw[PIN_CPU_OFF] = cpu_disabled;
  assign pin_raw[PIN_FAN_FAIL] = fan_fail;
  assign pin_raw[PIN_NONCRIT] = thresh_noncrit;
  assign pin_raw[PIN_UPPER_NC] = thresh_upper_noncrit;
  assign pin_raw[PIN_BATTERY] = battery_fail;
  assign pin_raw[PIN_PSU_PRED] = psu_predictive_fail;
  assign pin_raw[PIN_CRIT] = thresh_crit;
  assign pin_raw[PIN_REG_HOT] = regulator_overheat;
  assign pin_raw[PIN_FANS_LOW] = fans_below_min;
  assign pin_raw[PIN_CPU_INTERNAL] = cpu_internal_error;
  assign pin_raw[PIN_CPU1_ABSENT] = cpu1_missing;
  assign pin_raw[PIN_CPU_TRIP] = cpu_thermal_trip;
  assign pin_raw[PIN_PGOOD_LOST] = power_good_lost;
  assign pin_raw[PIN_PSU_SHORT] = psu_insufficient;
  assign pin_raw[PIN_HSC_DEG] = hsc_degraded;
  assign pin_raw[PIN_HSC_NF] = hsc_nonfatal;
  assign pin_raw[PIN_HSC_FATAL] = hsc_fatal;

  ssla_sync #(.WIDTH(NPIN)) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin_in(pin_raw),
    .level_out(pin_s)
  );

  wire blink_phase;
  // One divider for both colours keeps green and amber blinks in step
  ssla_blink #(.HALF_CYC(BLINK_HALF_CYC)) u_blink (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .blink_phase(blink_phase)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [3:0] ctrl_reg;
  reg [`SSLA_FW_WIDTH-1:0] fw_src_reg;
  reg [`SSLA_FW_WIDTH-1:0] fw_mask;
  reg aw_full_reg;
  reg w_full_reg;
  reg [7:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  wire wr_fire;
  wire [NPIN-1:0] bmc_src;

  assign bmc_src = pin_s;
  assign s_axi_awready = ~aw_full_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_full_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_fire = aw_full_reg & w_full_reg & ~s_axi_bvalid;

  // Address and data latched separately, in either order
  always @(posedge mclk) begin
    if (sys_rst) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_full_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_full_reg <= 1'b0;
      end
    end
  end

  // Set/clear strobes for firmware fault reports
  always @* begin
    fw_mask = w_data_reg[`SSLA_FW_WIDTH-1:0];
    if (!w_strb_reg[0]) begin
      fw_mask = {`SSLA_FW_WIDTH{1'b0}};
    end
  end

  // Register writes and write response; firmware reports are sticky until cleared
  always @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_reg <= `SSLA_CTRL_RESET;
      fw_src_reg <= {`SSLA_FW_WIDTH{1'b0}};
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        case (aw_addr_reg)
          `SSLA_OFF_CTRL: begin
            if (w_strb_reg[0]) begin
              ctrl_reg <= w_data_reg[3:0];
            end
          end
          `SSLA_OFF_FW_SET: begin
            fw_src_reg <= fw_src_reg | fw_mask;
          end
          `SSLA_OFF_FW_CLR: begin
            fw_src_reg <= fw_src_reg & ~fw_mask;
          end
          `SSLA_OFF_BMC_SRC, `SSLA_OFF_FW_SRC, `SSLA_OFF_STATUS, `SSLA_OFF_CFG: begin
            s_axi_bresp <= 2'b00;
          end
          default: begin
            s_axi_bresp <= 2'b10;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel, one cycle after the address is taken
  always @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      case (s_axi_araddr)
        `SSLA_OFF_CTRL: s_axi_rdata <= {28'h0000000, ctrl_reg};
        `SSLA_OFF_BMC_SRC: s_axi_rdata <= {13'h0000, bmc_src};
        `SSLA_OFF_FW_SRC: s_axi_rdata <= {24'h000000, fw_src_reg};
        `SSLA_OFF_STATUS: s_axi_rdata <= {27'h0, blink_phase, status_amber_n, status_green_n, severity};
        `SSLA_OFF_CFG: s_axi_rdata <= CFG_WORD;
        // Set and clear ports read as zero, so read-modify-write cannot re-apply a report
        `SSLA_OFF_FW_SET, `SSLA_OFF_FW_CLR: s_axi_rdata <= 32'h0000_0000;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Severity classification, recomputed every cycle from current sources
  reg deg_any;
  reg nf_any;
  reg fat_any;
  reg [1:0] sev_next;

  always @* begin
    deg_any = 1'b0;
    nf_any = 1'b0;
    fat_any = 1'b0;
    // Redundancy loss in power supplies or fans
    if (pin_s[PIN_PSU_REDUND]) deg_any = 1'b1;
    if (pin_s[PIN_FAN_REDUND]) deg_any = 1'b1;
    // A failed fan degrades whether or not enough fans remain
    if (pin_s[PIN_FAN_FAIL]) deg_any = 1'b1;
    if (pin_s[PIN_CPU_OFF] && ctrl_reg[`SSLA_CTRL_DUAL_CPU]) deg_any = 1'b1;
    if (pin_s[PIN_NONCRIT]) deg_any = 1'b1;
    // Upper non-critical only counts when tracking is enabled
    if (pin_s[PIN_UPPER_NC] && ctrl_reg[`SSLA_CTRL_UNC_EN]) deg_any = 1'b1;
    if (pin_s[PIN_BATTERY]) deg_any = 1'b1;
    if (pin_s[PIN_PSU_PRED] && ctrl_reg[`SSLA_CTRL_REDUND_PSU]) deg_any = 1'b1;
    if (pin_s[PIN_HSC_DEG]) deg_any = 1'b1;
    // Firmware degraded reports
    if (fw_src_reg[`SSLA_FW_MEM_UNUSABLE]) deg_any = 1'b1;
    if (fw_src_reg[`SSLA_FW_MEM_REDUND_LOST] && ctrl_reg[`SSLA_CTRL_MIRROR]) deg_any = 1'b1;
    if (fw_src_reg[`SSLA_FW_PCIE_CORR]) deg_any = 1'b1;
    // Non-fatal alarms
    if (pin_s[PIN_CRIT]) nf_any = 1'b1;
    if (pin_s[PIN_REG_HOT]) nf_any = 1'b1;
    if (pin_s[PIN_FANS_LOW]) nf_any = 1'b1;
    if (pin_s[PIN_HSC_NF]) nf_any = 1'b1;
    if (fw_src_reg[`SSLA_FW_MEM_CE_LIMIT] && !ctrl_reg[`SSLA_CTRL_MIRROR]) nf_any = 1'b1;
    if (fw_src_reg[`SSLA_FW_PCIE_UNCORR]) nf_any = 1'b1;
    // Fatal alarms
    if (pin_s[PIN_CPU_INTERNAL]) fat_any = 1'b1;
    if (pin_s[PIN_CPU1_ABSENT]) fat_any = 1'b1;
    if (pin_s[PIN_CPU_TRIP]) fat_any = 1'b1;
    if (pin_s[PIN_PGOOD_LOST]) fat_any = 1'b1;
    // Too few supplies fitted is a fatal power fault
    if (pin_s[PIN_PSU_SHORT]) fat_any = 1'b1;
    if (pin_s[PIN_HSC_FATAL]) fat_any = 1'b1;
    if (fw_src_reg[`SSLA_FW_NO_GOOD_DIMM]) fat_any = 1'b1;
    if (fw_src_reg[`SSLA_FW_MEM_UE] && !ctrl_reg[`SSLA_CTRL_MIRROR]) fat_any = 1'b1;
    if (fw_src_reg[`SSLA_FW_CPU_CONFIG]) fat_any = 1'b1;
    // Priority: highest severity present wins
    if (fat_any) begin
      sev_next = `SSLA_SEV_FATAL;
    end else if (nf_any) begin
      sev_next = `SSLA_SEV_NONFATAL;
    end else if (deg_any) begin
      sev_next = `SSLA_SEV_DEGRADED;
    end else begin
      sev_next = `SSLA_SEV_OK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indicator drive; only sys_rst clears state, power-state changes do not
  // Limitation: retention relies on the standby supply; there is no power-state input at all
  always @(posedge mclk) begin
    if (sys_rst) begin
      severity <= `SSLA_SEV_OK;
      status_green_n <= 1'b1;
      status_amber_n <= 1'b1;
    end else begin
      severity <= sev_next;
      case (sev_next)
        `SSLA_SEV_FATAL: begin
          status_green_n <= 1'b1;
          status_amber_n <= 1'b0;
        end
        `SSLA_SEV_NONFATAL: begin
          status_green_n <= 1'b1;
          status_amber_n <= ~blink_phase;
        end
        `SSLA_SEV_DEGRADED: begin
          status_green_n <= ~blink_phase;
          status_amber_n <= 1'b1;
        end
        default: begin
          status_green_n <= 1'b0;
          status_amber_n <= 1'b1;
        end
      endcase
    end
  end
endmodule // ssla_arbiter

// ==== bench/ssla_sensor_model.sv ====
// Sensor monitor and hot-swap controller model that drives the fault pins
`timescale 1ns/1ps
module ssla_sensor_model (
  input wire mclk,
  input wire [18:0] fault_req,
  output reg [18:0] fault_pins
);
  // Monitors change their levels just after the clock; the arbiter must still resynchronise them
  initial fault_pins = 19'h00000;
  always @(posedge mclk) begin
    fault_pins <= fault_req;
  end
endmodule // ssla_sensor_model

// ==== bench/ssla_arbiter_props.sv ====
// Port-level assertions for the status indicator arbiter
`timescale 1ns/1ps
module ssla_arbiter_props #(
  parameter BLINK_HALF_CYC = 8
) (
  input wire mclk,
  input wire sys_rst,
  input wire psu_redund_lost,
  input wire fan_fail,
  input wire battery_fail,
  input wire thresh_crit,
  input wire regulator_overheat,
  input wire fans_below_min,
  input wire cpu_internal_error,
  input wire cpu1_missing,
  input wire cpu_thermal_trip,
  input wire power_good_lost,
  input wire psu_insufficient,
  input wire hsc_degraded,
  input wire hsc_nonfatal,
  input wire hsc_fatal,
  input wire status_green_n,
  input wire status_amber_n,
  input wire [1:0] severity
);
  // Blink repetitions below assume the simulation half period of 8 cycles
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////////
  // Severity and both LEDs load from one next value, so they are compared in the same cycle
  property p_ok_solid;
    !$past(sys_rst) && severity == 2'h0 |-> !status_green_n && status_amber_n;
  endproperty
  a_ok_solid: assert property (p_ok_solid) else $error("green not steady at ok");
  property p_amber_wins;
    !$past(sys_rst) && severity[1] |-> status_green_n;
  endproperty
  a_amber_wins: assert property (p_amber_wins) else $error("green lit during amber state");
  property p_fatal_solid;
    !$past(sys_rst) && severity == 2'h3 |-> !status_amber_n;
  endproperty
  a_fatal_solid: assert property (p_fatal_solid) else $error("amber not steady at fatal");
  property p_green_blink;
    $rose(status_green_n) && severity == 2'h1 && $past(severity) == 2'h1 |=>
      (status_green_n || severity != 2'h1) [*7] ##1 (!status_green_n || severity != 2'h1);
  endproperty
  a_green_blink: assert property (p_green_blink) else $error("green blink period wrong");
  property p_amber_blink;
    $rose(status_amber_n) && severity == 2'h2 && $past(severity) == 2'h2 |=>
      (status_amber_n || severity != 2'h2) [*7] ##1 (!status_amber_n || severity != 2'h2);
  endproperty
  a_amber_blink: assert property (p_amber_blink) else $error("amber blink period wrong");
  property p_fatal_src;
    (cpu_internal_error || cpu1_missing || cpu_thermal_trip || power_good_lost || psu_insufficient || hsc_fatal) [*8]
      |-> severity == 2'h3;
  endproperty
  a_fatal_src: assert property (p_fatal_src) else $error("fatal source not fatal");
  property p_nf_src;
    (thresh_crit || regulator_overheat || fans_below_min || hsc_nonfatal) [*8] |-> severity[1];
  endproperty
  a_nf_src: assert property (p_nf_src) else $error("non-fatal source too low");
  property p_deg_src;
    (psu_redund_lost || fan_fail || battery_fail || hsc_degraded) [*8] |-> severity != 2'h0;
  endproperty
  a_deg_src: assert property (p_deg_src) else $error("degraded source ignored");
endmodule // ssla_arbiter_props
bind ssla_arbiter ssla_arbiter_props #(.BLINK_HALF_CYC(BLINK_HALF_CYC)) u_props (.mclk(mclk), .sys_rst(sys_rst),
  .psu_redund_lost(psu_redund_lost), .fan_fail(fan_fail), .battery_fail(battery_fail), .thresh_crit(thresh_crit),
  .regulator_overheat(regulator_overheat), .fans_below_min(fans_below_min), .cpu_internal_error(cpu_internal_error),
  .cpu1_missing(cpu1_missing), .cpu_thermal_trip(cpu_thermal_trip), .power_good_lost(power_good_lost),
  .psu_insufficient(psu_insufficient), .hsc_degraded(hsc_degraded), .hsc_nonfatal(hsc_nonfatal),
  .hsc_fatal(hsc_fatal), .status_green_n(status_green_n), .status_amber_n(status_amber_n), .severity(severity));

// ==== bench/ssla_arbiter_tb.sv ====
// Self-checking testbench for the status indicator arbiter
`timescale 1ns/1ps
`include "ssla_defines.vh"
module ssla_arbiter_tb;
  localparam HALF = 8;
  reg mclk = 1'b0;
  reg sys_rst = 1'b1;
  reg [18:0] fault_req = 19'h00000;
  wire [18:0] fp;
  reg [7:0] awaddr = 8'h00, araddr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, green_n, amber_n;
  wire [1:0] bresp, rresp, sev;
  wire [31:0] rdata;
  int err_count = 0;
  int samples_checked = 0;
  ssla_sensor_model u_sens (.mclk(mclk), .fault_req(fault_req), .fault_pins(fp));
  ssla_arbiter #(.BLINK_HALF_CYC(HALF)) DUT (.mclk(mclk), .sys_rst(sys_rst), .psu_redund_lost(fp[0]),
    .fan_redund_lost(fp[1]), .cpu_disabled(fp[2]), .fan_fail(fp[3]), .thresh_noncrit(fp[4]),
    .thresh_upper_noncrit(fp[5]), .battery_fail(fp[6]), .psu_predictive_fail(fp[7]), .thresh_crit(fp[8]),
    .regulator_overheat(fp[9]), .fans_below_min(fp[10]), .cpu_internal_error(fp[11]), .cpu1_missing(fp[12]),
    .cpu_thermal_trip(fp[13]), .power_good_lost(fp[14]), .psu_insufficient(fp[15]), .hsc_degraded(fp[16]),
    .hsc_nonfatal(fp[17]), .hsc_fatal(fp[18]), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .status_green_n(green_n), .status_amber_n(amber_n), .severity(sev));
  ////////////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and bus tasks; ready is judged at the falling edge, where it equals the next rising edge
  task automatic check(input [31:0] seen, input [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    if (err_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic axi_wr(input [7:0] a, input [31:0] d, input [1:0] er);
    reg ta, tw, tb;
    tb = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int n = 0; n < 40 && !tb; n++) begin
      @(negedge mclk);
      ta = awready && awvalid;
      tw = wready && wvalid;
      tb = bvalid;
      if (tb) check({30'h0, bresp}, {30'h0, er});
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    if (!tb) err_count++;
    if (!tb) end_sim;
  endtask
  task automatic axi_rd(input [7:0] a, output [31:0] d, output [1:0] r);
    reg ta, tk;
    tk = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    for (int n = 0; n < 40 && !tk; n++) begin
      @(negedge mclk);
      ta = arready && arvalid;
      tk = rvalid;
      d = rdata;
      r = rresp;
      @(posedge mclk);
      if (ta) arvalid <= 1'b0;
    end
    if (!tk) err_count++;
    if (!tk) end_sim;
  endtask
  task automatic rd_chk(input [7:0] a, input [31:0] e, input [1:0] er);
    reg [31:0] d;
    reg [1:0] r;
    axi_rd(a, d, r);
    check(d, e);
    check({30'h0, r}, {30'h0, er});
  endtask
  // Expected severity of one pin or one firmware report, by the mapping of conditions to states
  function automatic [1:0] exp_pin(input int i, input [3:0] c);
    case (i)
      2: exp_pin = {1'b0, c[`SSLA_CTRL_DUAL_CPU]};
      5: exp_pin = {1'b0, c[`SSLA_CTRL_UNC_EN]};
      7: exp_pin = {1'b0, c[`SSLA_CTRL_REDUND_PSU]};
      8, 9, 10, 17: exp_pin = `SSLA_SEV_NONFATAL;
      11, 12, 13, 14, 15, 18: exp_pin = `SSLA_SEV_FATAL;
      default: exp_pin = `SSLA_SEV_DEGRADED;
    endcase
  endfunction
  function automatic [1:0] exp_fw(input int i, input m);
    case (i)
      1: exp_fw = {1'b0, m};
      3: exp_fw = m ? `SSLA_SEV_OK : `SSLA_SEV_NONFATAL;
      4: exp_fw = `SSLA_SEV_NONFATAL;
      5, 7: exp_fw = `SSLA_SEV_FATAL;
      6: exp_fw = m ? `SSLA_SEV_OK : `SSLA_SEV_FATAL;
      default: exp_fw = `SSLA_SEV_DEGRADED;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs;
    reg [31:0] d;
    reg [1:0] r;
    rd_chk(`SSLA_OFF_CTRL, `SSLA_CTRL_RESET, 2'b00);
    rd_chk(`SSLA_OFF_CFG, HALF, 2'b00);
    rd_chk(8'h1c, 32'h0, 2'b10);
    axi_wr(8'h1c, 32'hffff_ffff, 2'b10);
    axi_wr(`SSLA_OFF_STATUS, 32'hffff_ffff, 2'b00);
    axi_rd(`SSLA_OFF_STATUS, d, r);
    check({28'h0, d[3:0]}, 32'h8);
    check({30'h0, sev}, 32'h0);
  endtask
  task automatic t_pins;
    for (int c = 0; c < 2; c++) begin
      axi_wr(`SSLA_OFF_CTRL, c ? 32'hf : 32'h0, 2'b00);
      for (int i = 0; i < 19; i++) begin
        fault_req <= 19'h1 << i;
        repeat (8) @(posedge mclk);
        check({30'h0, sev}, {30'h0, exp_pin(i, c ? 4'hf : 4'h0)});
        rd_chk(`SSLA_OFF_BMC_SRC, 32'h1 << i, 2'b00);
        fault_req <= 19'h00000;
        repeat (8) @(posedge mclk);
        check({30'h0, sev}, 32'h0);
      end
    end
  endtask
  task automatic t_fw;
    for (int m = 0; m < 2; m++) begin
      axi_wr(`SSLA_OFF_CTRL, m ? 32'h4 : 32'h0, 2'b00);
      for (int i = 0; i < 8; i++) begin
        axi_wr(`SSLA_OFF_FW_SET, 32'h1 << i, 2'b00);
        repeat (2) @(posedge mclk);
        check({30'h0, sev}, {30'h0, exp_fw(i, m[0])});
        rd_chk(`SSLA_OFF_FW_SRC, 32'h1 << i, 2'b00);
        axi_wr(`SSLA_OFF_FW_CLR, 32'h1 << i, 2'b00);
        repeat (2) @(posedge mclk);
        check({30'h0, sev}, 32'h0);
      end
    end
  endtask
  task automatic t_prio;
    int len;
    fault_req <= 19'h12001;
    axi_wr(`SSLA_OFF_FW_SET, 32'h10, 2'b00);
    repeat (8) @(posedge mclk);
    check({30'h0, sev}, 32'h3);
    check({30'h0, green_n, amber_n}, 32'h2);
    fault_req <= 19'h10001;
    repeat (8) @(posedge mclk);
    check({30'h0, sev}, 32'h2);
    axi_wr(`SSLA_OFF_FW_CLR, 32'h10, 2'b00);
    repeat (2) @(posedge mclk);
    check({30'h0, sev}, 32'h1);
  endtask
  // One half period of the blinking element, counted in cycles between two changes
  task automatic half_len(input sel, output int len);
    reg v;
    int k;
    k = 0;
    len = 0;
    v = sel ? amber_n : green_n;
    for (int n = 0; n < 60 && k < 2; n++) begin
      @(negedge mclk);
      if (k == 1) len++;
      if ((sel ? amber_n : green_n) !== v) k++;
      v = sel ? amber_n : green_n;
    end
    @(posedge mclk);
  endtask
  task automatic t_blink;
    int len;
    half_len(1'b0, len);
    check(len, HALF);
    fault_req <= 19'h10101;
    repeat (8) @(posedge mclk);
    half_len(1'b1, len);
    check(len, HALF);
    check({31'h0, green_n}, 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, reset and main sequence
  initial begin
    forever #4 mclk = ~mclk;
  end
  initial begin
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    t_regs;
    t_pins;
    t_fw;
    t_prio;
    t_blink;
    end_sim;
  end
endmodule // ssla_arbiter_tb
